// ---- logic/smcsc_top.sv ----
/*
  static memory chip-select controller: area decode, lane steering,
  wait-state sequencing and strobe generation for non-dram memories.
  assumes a cpu/dma requester on clk_sys_i holding its request stable
  until the last acknowledge; wait pin is asynchronous.
*/
// Contract
// - 16-bit area: be upper half, le lower
// - 8-bit area: be top byte, le low
// - reverse-endian bit never changes lanes
// - external wait inserts states, delays start
// - all spaces but dram are served
// - eight areas, own active-low select each
// - area size 8 KB to 256 MB
// - address compared with base and mask
// - single and burst reads and writes
// - control picks 8/16/32 or interleaved
// - interleave only on fixed even/odd pairs
// - per-area transceiver strobe style selectable
// - interleaved boot area defaults to mux
// - first-word and between-word waits timed separately
// - generates read capture and acknowledge strobes
// - single reads, all writes: ack at end
// - burst read ack at programmed beat
// - wait acts two clocks after assertion
// - wait after a word delays next word
// - select asserts at start, drops at end
// - interleaved: both on read, one on write
`timescale 1ns/1ps
`default_nettype none
`include "smcsc_defs.svh"
module smcsc_top
  import smcsc_pkg::*;
#(
  parameter int NUM_AREAS = `SMCSC_NUM_AREAS,
  parameter int WAIT_W = `SMCSC_WAIT_W,
  parameter int BEAT_W = `SMCSC_BEAT_W
)(
  input wire logic clk_sys_i, // 250 MHz system clock
  input wire logic rst_i, // async reset, active high
  input wire logic big_endian_i, // system endianness strap level
  input wire logic reverse_endian_i, // user reverse-endian bit, ignored
  input wire logic boot_interleaved_i, // boot area 0/1 interleaved
  input wire logic dram_space_i, // request belongs to dram controller
  input wire logic req_i, // cpu_bus_interface or dma request
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [BEAT_W-1:0] req_beats_i, // burst length minus one
  input wire logic [`SMCSC_ADDR_W-1:0] req_addr_i, // transaction address
  input wire logic [31:0] wdata_i, // write word, cpu lanes
  input wire logic [NUM_AREAS*`SMCSC_ADDR_W-1:0] area_base_i, // per-area base
  input wire logic [NUM_AREAS*`SMCSC_ADDR_W-1:0] area_mask_i, // per-area size mask
  input wire logic [NUM_AREAS*`SMCSC_CTRL_W-1:0] area_ctrl_i, // width, xcvr, burst ack
  input wire logic [NUM_AREAS*WAIT_W-1:0] area_first_wait_i, // waits to first word
  input wire logic [NUM_AREAS*WAIT_W-1:0] area_next_wait_i, // waits between words
  input wire logic external_wait_n_i, // active-low wait pin
  output logic [NUM_AREAS-1:0] area_chip_select_n_o, // active-low selects
  output logic [`SMCSC_EXT_ADDR_W-1:0] mem_addr_o, // external address
  output logic [31:0] system_data_bus_o, // steered write data
  output logic system_data_oe_o, // data bus drive enable
  output logic read_enable_even_n_o, // even bank read strobe
  output logic read_enable_odd_n_o, // odd bank read strobe
  output logic read_capture_enable_n_o, // internal read capture strobe
  output logic transfer_acknowledge_n_o, // internal acknowledge
  output logic [NUM_AREAS-1:0] area_match_o // decode result, for visibility
);
  // refused at elaboration: area index and selects are sized for eight areas
  if (NUM_AREAS < 2 || NUM_AREAS > 8 || NUM_AREAS % 2 != 0)
  begin : g_bad_areas
    $error("NUM_AREAS must be an even count from 2 to 8");
  end
  if (WAIT_W < 1 || BEAT_W < 1 || BEAT_W > `SMCSC_CTRL_W - `SMCSC_BACK_LSB)
  begin : g_bad_widths
    $error("WAIT_W and BEAT_W out of range");
  end

  localparam int AW = `SMCSC_ADDR_W;
  localparam int CW = `SMCSC_CTRL_W;

  logic wait_m_q, wait_s_q, wait_m_d, wait_s_d;
  smcsc_state_t state_q, state_d;
  logic [NUM_AREAS-1:0] cs_n_q, cs_n_d, match;
  logic [2:0] area_q, area_d, hit_idx;
  logic hit;
  logic [WAIT_W-1:0] cnt_q, cnt_d;
  logic [BEAT_W-1:0] beat_q, beat_d, beats_q, beats_d;
  logic wr_q, wr_d, phase_q, phase_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [25:0] ma_q, ma_d;
  logic [31:0] dat_q, dat_d;
  logic oe_q, oe_d, re_even_q, re_even_d, re_odd_q, re_odd_d;
  logic rce_q, rce_d, ack_q, ack_d;
  logic [CW-1:0] ctrl;
  smcsc_width_t width;
  smcsc_xcvr_t xcvr;
  logic [BEAT_W-1:0] back_pos;
  logic [WAIT_W-1:0] w_first, w_next;
  logic word_done, last;

  // wait pin is asynchronous; second stage is also the pipeline delay
  always_comb
  begin
    wait_m_d = external_wait_n_i;
    wait_s_d = wait_m_q;
  end

  // decode: base/mask compare, lowest area wins, dram space excluded
  always_comb
  begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = 0; i < NUM_AREAS; i++)
    begin
      match[i] = ((req_addr_i ^ area_base_i[i*AW +: AW]) & area_mask_i[i*AW +: AW])
                 == {AW{1'b0}} && !dram_space_i;
    end
    for (int i = NUM_AREAS - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // per-area fields of the active area
  always_comb
  begin
    ctrl = area_ctrl_i[area_q*CW +: CW];
    width = smcsc_width_t'(ctrl[`SMCSC_WIDTH_LSB +: 2]);
    xcvr = smcsc_xcvr_t'(ctrl[`SMCSC_XCVR_LSB +: 2]);
    if (area_q[2:1] == 2'b00 && boot_interleaved_i)
    begin
      width = SMCSC_WIL;
      xcvr = SMCSC_X_MUX;
    end
    back_pos = ctrl[`SMCSC_BACK_LSB +: BEAT_W];
    w_first = area_first_wait_i[area_q*WAIT_W +: WAIT_W];
    w_next = area_next_wait_i[area_q*WAIT_W +: WAIT_W];
  end

  // a word completes when its wait count is spent and the pin allows
  assign word_done = (cnt_q == {WAIT_W{1'b0}}) && wait_s_q;
  assign last = (beat_q == beats_q);

  always_comb
  begin
    state_d = state_q;
    cs_n_d = cs_n_q;
    area_d = area_q;
    cnt_d = cnt_q;
    beat_d = beat_q;
    beats_d = beats_q;
    wr_d = wr_q;
    phase_d = phase_q;
    addr_d = addr_q;
    ma_d = ma_q;
    dat_d = dat_q;
    oe_d = 1'b0;
    re_even_d = 1'b1;
    re_odd_d = 1'b1;
    rce_d = 1'b1;
    ack_d = 1'b1;
    case (state_q)
      SMCSC_IDLE:
      begin
        cs_n_d = {NUM_AREAS{1'b1}};
        if (req_i && hit && wait_s_q) // start held off by wait
        begin
          state_d = SMCSC_FIRST;
          area_d = hit_idx;
          wr_d = req_write_i;
          beats_d = req_beats_i;
          beat_d = {BEAT_W{1'b0}};
          addr_d = req_addr_i;
          cnt_d = area_first_wait_i[hit_idx*WAIT_W +: WAIT_W];
          phase_d = 1'b0;
        end
      end
      SMCSC_FIRST, SMCSC_NEXT:
      begin
        ma_d = addr_q[25:0];
        // interleaved: pair on reads, one bank per write word
        if (width == SMCSC_WIL && !wr_q)
          cs_n_d = ~(NUM_AREAS'(3) << {area_q[2:1], 1'b0});
        else if (width == SMCSC_WIL)
          cs_n_d = ~(NUM_AREAS'(1) << {area_q[2:1], phase_q});
        else
          cs_n_d = ~(NUM_AREAS'(1) << area_q);
        // lanes depend only on the strap, never on the reverse-endian bit
        case (width)
          SMCSC_W16: dat_d = big_endian_i ? {wdata_i[15:0], 16'h0000}
                                          : {16'h0000, wdata_i[15:0]};
          SMCSC_W8: dat_d = big_endian_i ? {wdata_i[7:0], 24'h000000}
                                         : {24'h000000, wdata_i[7:0]};
          default: dat_d = wdata_i;
        endcase
        oe_d = wr_q;
        if (!wr_q && width == SMCSC_WIL)
        begin
          // mux style keeps even enable on for both banks
          re_even_d = !(!phase_q || xcvr == SMCSC_X_MUX);
          re_odd_d = !(phase_q || xcvr != SMCSC_X_MUX);
        end
        else if (!wr_q)
        begin
          // a lone bank shares its enable with banks of the same parity
          re_even_d = area_q[0];
          re_odd_d = !area_q[0];
        end
        if (cnt_q != {WAIT_W{1'b0}})
          cnt_d = cnt_q - WAIT_W'(1);
        if (word_done)
        begin
          rce_d = wr_q;
          if (!wr_q && beats_q != {BEAT_W{1'b0}} && beat_q == back_pos)
            ack_d = 1'b0;
          if (last)
          begin
            state_d = SMCSC_DONE;
            if (wr_q || beats_q == {BEAT_W{1'b0}})
              ack_d = 1'b0;
          end
          else
          begin
            state_d = SMCSC_NEXT;
            beat_d = beat_q + BEAT_W'(1);
            cnt_d = w_next;
            addr_d = addr_q + AW'(4);
            phase_d = ~phase_q;
          end
        end
      end
      SMCSC_DONE:
      begin
        cs_n_d = {NUM_AREAS{1'b1}};
        state_d = SMCSC_IDLE;
      end
      default: state_d = SMCSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_m_q <= 1'b1;
      wait_s_q <= 1'b1;
      state_q <= SMCSC_IDLE;
      cs_n_q <= {NUM_AREAS{1'b1}};
      area_q <= 3'h0;
      cnt_q <= {WAIT_W{1'b0}};
      beat_q <= {BEAT_W{1'b0}};
      beats_q <= {BEAT_W{1'b0}};
      wr_q <= 1'b0;
      phase_q <= 1'b0;
      addr_q <= {AW{1'b0}};
      ma_q <= 26'h0000000;
      dat_q <= 32'h00000000;
      oe_q <= 1'b0;
      re_even_q <= 1'b1;
      re_odd_q <= 1'b1;
      rce_q <= 1'b1;
      ack_q <= 1'b1;
    end
    else
    begin
      wait_m_q <= wait_m_d;
      wait_s_q <= wait_s_d;
      state_q <= state_d;
      cs_n_q <= cs_n_d;
      area_q <= area_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
      beats_q <= beats_d;
      wr_q <= wr_d;
      phase_q <= phase_d;
      addr_q <= addr_d;
      ma_q <= ma_d;
      dat_q <= dat_d;
      oe_q <= oe_d;
      re_even_q <= re_even_d;
      re_odd_q <= re_odd_d;
      rce_q <= rce_d;
      ack_q <= ack_d;
    end
  end

  logic [NUM_AREAS-1:0] match_q, match_d;
  always_comb
  begin
    match_d = match & {NUM_AREAS{req_i}};
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      match_q <= {NUM_AREAS{1'b0}};
    else
      match_q <= match_d;
  end

  assign area_chip_select_n_o = cs_n_q;
  assign mem_addr_o = ma_q;
  assign system_data_bus_o = dat_q;
  assign system_data_oe_o = oe_q;
  assign read_enable_even_n_o = re_even_q;
  assign read_enable_odd_n_o = re_odd_q;
  assign read_capture_enable_n_o = rce_q;
  assign transfer_acknowledge_n_o = ack_q;
  assign area_match_o = match_q;
endmodule // smcsc_top
`default_nettype wire

// ---- logic/smcsc_defs.svh ----
/*
  timing counts, field positions and reset values of the static memory
  chip-select controller. assumes inclusion by logic/smcsc_pkg.sv and the top.
*/
`ifndef SMCSC_DEFS_SVH
`define SMCSC_DEFS_SVH
`define SMCSC_NUM_AREAS 8
`define SMCSC_ADDR_W 32
`define SMCSC_EXT_ADDR_W 26
`define SMCSC_MIN_AREA_BITS 13
`define SMCSC_MAX_AREA_BITS 28
`define SMCSC_WAIT_W 4
`define SMCSC_BEAT_W 2
`define SMCSC_WAIT_PIPE 2
`define SMCSC_BACK_ADVICE 3
`define SMCSC_WIDTH_LSB 0
`define SMCSC_XCVR_LSB 2
`define SMCSC_BACK_LSB 4
`define SMCSC_CTRL_W 8
`define SMCSC_CTRL_RST 8'h00
`endif

// ---- logic/smcsc_pkg.sv ----
/*
  types of the static memory chip-select controller: port widths,
  transceiver styles and sequencer states. assumes smcsc_defs.svh.
*/
`include "smcsc_defs.svh"
package smcsc_pkg;
  typedef enum logic [1:0] {SMCSC_W8, SMCSC_W16, SMCSC_W32, SMCSC_WIL} smcsc_width_t;
  typedef enum logic [1:0] {SMCSC_X_DIRECT, SMCSC_X_MUX, SMCSC_X_UNI, SMCSC_X_REG} smcsc_xcvr_t;
  typedef enum {SMCSC_IDLE, SMCSC_FIRST, SMCSC_NEXT, SMCSC_DONE} smcsc_state_t;
endpackage

// ---- tb/smcsc_asserts.sv ----
/* port assertions of smcsc_top.
   assumes the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module smcsc_asserts #(parameter int NUM_AREAS = 8)(
  input wire logic clk_sys_i, // clock
  input wire logic rst_i, // reset
  input wire logic req_i, // request
  input wire logic dram_space_i, // dram space
  input wire logic external_wait_n_i, // wait pin
  input wire logic [NUM_AREAS-1:0] area_chip_select_n_o, // selects
  input wire logic [NUM_AREAS-1:0] area_match_o, // decode
  input wire logic system_data_oe_o, // write drive
  input wire logic read_capture_enable_n_o, // capture
  input wire logic transfer_acknowledge_n_o // ack
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic idle;
  assign idle = &area_chip_select_n_o;
  // three low samples outlast the two-flop delay
  sequence wait_held;
    !external_wait_n_i [*3];
  endsequence
  dram_off_a: assert property (req_i && dram_space_i |=> area_match_o == '0)
    else $error("dram request decoded");
  ack_pulse_a: assert property (!transfer_acknowledge_n_o |=> transfer_acknowledge_n_o)
    else $error("ack too long");
  cap_read_a: assert property (!read_capture_enable_n_o |-> !system_data_oe_o && !idle)
    else $error("capture outside read");
  wr_single_a: assert property (system_data_oe_o |-> $onehot(~area_chip_select_n_o))
    else $error("write select not single");
  wr_end_a: assert property (!transfer_acknowledge_n_o && system_data_oe_o |=> idle)
    else $error("select held after write");
  wait_stall_a: assert property (wait_held |-> ##1 transfer_acknowledge_n_o)
    else $error("ack during wait");
  idle_quiet_a: assert property (idle |-> transfer_acknowledge_n_o && read_capture_enable_n_o)
    else $error("strobe while deselected");
  oe_match_a: assert property (system_data_oe_o |-> area_match_o != '0)
    else $error("write without match");
endmodule // smcsc_asserts
bind smcsc_top smcsc_asserts #(.NUM_AREAS(NUM_AREAS)) smcsc_asserts_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .dram_space_i(dram_space_i),
  .external_wait_n_i(external_wait_n_i), .area_chip_select_n_o(area_chip_select_n_o),
  .area_match_o(area_match_o), .system_data_oe_o(system_data_oe_o),
  .read_capture_enable_n_o(read_capture_enable_n_o),
  .transfer_acknowledge_n_o(transfer_acknowledge_n_o));
`default_nettype wire

// ---- tb/smcsc_wait_src.sv ----
/* busy dual-port memory driving the wait line.
   assumes start_i is changed by nonblocking assignment. */
`timescale 1ns/1ps
`default_nettype none
module smcsc_wait_src (
  input wire logic clk_i, // clock
  input wire logic start_i, // begin busy spell
  input wire logic [3:0] hold_i, // spell length
  output logic wait_n_o // pulled-up wait line
);
  logic [3:0] left_q = 4'h0;
  // falling edge, so the pin is settled when sampled
  always @(negedge clk_i)
    if (start_i)
      left_q <= hold_i;
    else if (left_q != 4'h0)
      left_q <= left_q - 4'h1;
  assign wait_n_o = (left_q == 4'h0);
endmodule // smcsc_wait_src
`default_nettype wire

// ---- tb/testbench.sv ----
/* self-checking bench of smcsc_top.
   assumes the logic/ files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst = 1'h1, be = 1'h1, rev = 1'h0, il = 1'h0, dram = 1'h0;
  logic req = 1'h0, wr = 1'h0, st = 1'h0, oe, cap_n, ack_n, wait_n;
  logic [1:0] beats = 2'h0;
  logic [3:0] hold = 4'h0;
  logic [31:0] addr = '0, wd = '0, fw = '0, nw = '0, bus, bus_seen;
  logic [255:0] base, mask;
  logic [63:0] ctrl = '0;
  logic [7:0] cs_n, match, cs_seen;
  logic re_e, re_o;
  logic [25:0] maddr;
  int n_fail = 0, n_tests = 0, seed = 46205, cyc, acks, ack_at, i;
  int wid[8], bk[8], fwt[8];
  int cap_q[$];
  always #2 clk = ~clk;
  smcsc_top smcsc_top_inst (.clk_sys_i(clk), .rst_i(rst), .big_endian_i(be),
    .reverse_endian_i(rev), .boot_interleaved_i(il), .dram_space_i(dram), .req_i(req),
    .req_write_i(wr), .req_beats_i(beats), .req_addr_i(addr), .wdata_i(wd),
    .area_base_i(base), .area_mask_i(mask), .area_ctrl_i(ctrl), .area_first_wait_i(fw),
    .area_next_wait_i(nw), .external_wait_n_i(wait_n), .area_chip_select_n_o(cs_n),
    .mem_addr_o(maddr), .system_data_bus_o(bus), .system_data_oe_o(oe),
    .read_enable_even_n_o(re_e), .read_enable_odd_n_o(re_o), .read_capture_enable_n_o(cap_n),
    .transfer_acknowledge_n_o(ack_n), .area_match_o(match));
  smcsc_wait_src smcsc_wait_src_inst (.clk_i(clk), .start_i(st), .hold_i(hold),
    .wait_n_o(wait_n));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cfg(int a, int w, int b, int f);
    wid[a] = w;
    bk[a] = b;
    fwt[a] = f;
    ctrl[a*8+:8] = 8'(w + b * 16);
    fw[a*4+:4] = 4'(f);
    nw[a*4+:4] = 4'(f);
  endtask
  // narrow data is replicated so the lane mask picks the checked byte lanes
  function automatic logic [31:0] lanes(int w, logic [31:0] d);
    return w == 0 ? {4{d[7:0]}} : w == 1 ? {2{d[15:0]}} : d;
  endfunction
  function automatic logic [31:0] lmask(int w, logic b);
    return w == 0 ? (b ? 32'hff000000 : 32'h000000ff) :
      w == 1 ? (b ? 32'hffff0000 : 32'h0000ffff) : 32'hffffffff;
  endfunction
  task automatic xfer(int a, logic w_r, int nb, int k);
    int t;
    logic [7:0] ecs;
    logic [31:0] m;
    logic [1:0] rs;
    if (k != 0)
    begin
      hold = 4'(k);
      st <= 1'h1;
      repeat (3) @(negedge clk);
      st <= 1'h0;
    end
    @(negedge clk);
    addr = {8'(a), 24'h0} | (32'($random(seed)) & 32'h00fffff0);
    wd = $random(seed);
    rev = 1'($random(seed));
    ctrl[a*8+2+:2] = 2'($random(seed));
    wr = w_r;
    beats = 2'(nb);
    req = 1'h1;
    cap_q = {};
    acks = 0;
    ack_at = 0;
    cs_seen = 8'hff;
    rs = 2'h0;
    for (cyc = 1; cyc < 60 && !(req == 1'h0 && cs_n === 8'hff); cyc++)
    begin
      @(negedge clk);
      if (cs_seen === 8'hff)
        cs_seen = cs_n;
      if (oe === 1'h1)
        bus_seen = bus;
      if (cap_n === 1'h0)
        cap_q.push_back(cyc);
      rs = rs | {re_o === 1'h0, re_e === 1'h0};
      if (ack_n === 1'h0)
      begin
        acks++;
        ack_at = cyc;
        req = 1'h0;
      end
    end
    req = 1'h0;
    chk("finished", 1, cyc < 60);
    t = fwt[a] + 2 + ((w_r || nb == 0) ? nb : bk[a]) * (fwt[a] + 1);
    ecs = (il && a < 2 && !w_r) ? 8'hfc : ~(8'h01 << a);
    m = lmask(wid[a], be);
    chk("select", ecs, cs_seen);
    chk("acks", 1, acks);
    chk("captures", w_r ? 0 : nb + 1, cap_q.size());
    if (k == 0)
      chk("ack time", t, ack_at);
    else
      chk("stall", t + k + 1, ack_at);
    if (w_r)
      chk("lanes", lanes(wid[a], wd) & m, bus_seen & m);
    chk("end address", (addr + 32'(4 * nb)) & 32'h03ffffff, 32'(maddr));
    chk("read enables", w_r ? 0 : (il && a < 2) ? 3 : (a % 2 == 1) ? 2 : 1, rs);
  endtask
  // whole run is under 2000 cycles; this cuts a hang
  initial
  begin
    #40000;
    n_fail++;
    give_verdict;
  end
  initial
  begin
    for (i = 0; i < 8; i++)
    begin
      base[i*32+:32] = {8'(i), 24'h0};
      mask[i*32+:32] = 32'hff000000;
    end
    repeat (20) @(negedge clk);
    rst = 1'h0;
    for (i = 0; i < 16; i++)
    begin
      be = i[3];
      cfg(i % 8, i % 3, 0, i % 4);
      xfer(i % 8, 1'h1, 0, 0);
      xfer(i % 8, 1'h0, 0, 0);
    end
    for (i = 0; i < 4; i++)
    begin
      cfg(3, 2, i, 1);
      xfer(3, 1'h0, 3, 0);
    end
    xfer(3, 1'h1, 3, 0);
    cfg(4, 2, 0, 2);
    xfer(4, 1'h0, 0, 6);
    xfer(4, 1'h1, 1, 6);
    for (i = 0; i < 2; i++)
    begin
      @(negedge clk);
      dram = !i[0];
      addr = i[0] ? 32'hf0000000 : 32'h05000000;
      req = 1'h1;
      repeat (6) @(negedge clk);
      chk("refused select", 8'hff, cs_n);
      chk("refused match", 8'h00, match);
      req = 1'h0;
      dram = 1'h0;
    end
    il = 1'h1;
    base[63:32] = base[31:0];
    cfg(0, 3, 0, 1);
    cfg(1, 3, 0, 1);
    xfer(0, 1'h0, 1, 0);
    xfer(0, 1'h1, 1, 0);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
